//--- sxq_defs.svh
// Offsets, field positions, reset values and write masks of the SIMD fault qualifier
`ifndef SXQ_DEFS_SVH
`define SXQ_DEFS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SXQ_OFS_CTL_ZERO   5'h00
`define SXQ_OFS_CTL_FOUR   5'h04
`define SXQ_OFS_FLAGS      5'h08
`define SXQ_OFS_VCS        5'h0C
`define SXQ_OFS_ID_EDX     5'h10
`define SXQ_OFS_ID_ECX     5'h14
`define SXQ_OFS_STATUS     5'h18
`define SXQ_OFS_FEAT       5'h1C
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SXQ_B_MONITOR      1
`define SXQ_B_SOFT_TRAP    2
`define SXQ_B_TASK_SW      3
`define SXQ_B_ALIGN_MASK   18
`define SXQ_B_STATE_SAVE   9
`define SXQ_B_VEC_HANDLER  10
`define SXQ_B_ALIGN_FLAG   18
`define SXQ_B_ID_GEN1      25
`define SXQ_B_ID_GEN2      26
`define SXQ_B_ID_STATE_SAVE_FEATURE      24
`define SXQ_B_ID_GEN3      0
`define SXQ_B_ID_SUPP3     9
`define SXQ_B_ID_GEN41     19
`define SXQ_B_ID_GEN42     20
`define SXQ_B_ID_BIT_POPULATION_COUNT    23
`define SXQ_B_VCS_MASK_LO  7
`define SXQ_B_VCS_MASK_HI  12
`define SXQ_B_ST_CFG_GP    8
`define SXQ_B_ST_COMMIT    16
// ----------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------
`define SXQ_RST_CTL_ZERO   32'h0000_0000
`define SXQ_RST_CTL_FOUR   32'h0000_0000
`define SXQ_RST_FLAGS      32'h0000_0000
`define SXQ_RST_VCS        32'h0000_0000
`define SXQ_WM_CTL_ZERO    32'h0004_000E
`define SXQ_WM_CTL_FOUR    32'h0000_0600
`define SXQ_WM_FLAGS       32'h0004_0000
`define SXQ_WM_VCS         32'h0000_FFFF
`define SXQ_USER_CPL       2'h3
`endif

//--- sxq_pkg.sv
// Types shared by the SIMD fault qualifier modules
`default_nettype none
package sxq_pkg;
  typedef enum logic [3:0] {
    SXQ_GEN1, SXQ_GEN2, SXQ_GEN3, SXQ_SUPP3, SXQ_GEN41, SXQ_GEN42,
    SXQ_NOSTATE, SXQ_MMX64, SXQ_LFLUSH, SXQ_CRC, SXQ_BIT_POPULATION_COUNT,
    SXQ_FPTRUNC, SXQ_MOVU
  } sxq_class_t;
  typedef enum logic [2:0] {
    SXQ_NONE, SXQ_UD, SXQ_NM, SXQ_XM, SXQ_GP, SXQ_SS, SXQ_AC, SXQ_PF
  } sxq_fault_t;
  typedef enum logic [1:0] {SXQ_SZ16, SXQ_SZ32, SXQ_SZ64, SXQ_SZ128} sxq_size_t;
endpackage
`default_nettype wire

//--- sxq_req_if.sv
// Request and verdict bundle between the qualifier top and its decision logic
`timescale 1ns/1ps
`default_nettype none
interface sxq_req_if;
  import sxq_pkg::*;
  sxq_class_t cls;
  sxq_size_t  size;
  logic [3:0] addr_lo;
  logic       stack_ref;
  logic       seg_viol;
  logic       page_miss;
  logic       fp_unmasked;
  logic       soft_trap;
  logic       task_sw;
  logic       align_en;
  logic       state_save;
  logic       vec_handler;
  logic [8:0] feat;
  sxq_fault_t fault;
  modport top  (output cls, size, addr_lo, stack_ref, seg_viol, page_miss, fp_unmasked,
                soft_trap, task_sw, align_en, state_save, vec_handler, feat, input fault);
  modport qual (input cls, size, addr_lo, stack_ref, seg_viol, page_miss, fp_unmasked,
                soft_trap, task_sw, align_en, state_save, vec_handler, feat, output fault);
endinterface
`default_nettype wire

//--- sxq_decide.sv
// Priority decision of the fault raised by one SIMD instruction
`timescale 1ns/1ps
`default_nettype none
module sxq_decide (
  sxq_req_if.qual req
);
  import sxq_pkg::*;
  logic feat_ok;
  logic em_exempt;
  logic os_exempt;
  logic ts_exempt;
  logic mis128;
  logic mis_small;
  // ----------------------------------------------------------------
  // Per-class feature and exemption
  // ----------------------------------------------------------------
  always_comb begin
    feat_ok   = 1'b0;
    em_exempt = 1'b0;
    os_exempt = 1'b0;
    ts_exempt = 1'b0;
    case (req.cls)
      SXQ_GEN1, SXQ_MOVU: feat_ok = req.feat[0];
      SXQ_GEN2:    feat_ok = req.feat[1];
      SXQ_GEN3:    feat_ok = req.feat[2];
      SXQ_SUPP3:   feat_ok = req.feat[3];
      SXQ_GEN41:   feat_ok = req.feat[4];
      SXQ_GEN42:   feat_ok = req.feat[5];
      SXQ_FPTRUNC: begin
        feat_ok   = req.feat[2];
        os_exempt = 1'b1;
      end
      SXQ_MMX64: begin
        feat_ok   = req.feat[0];
        os_exempt = 1'b1;
      end
      SXQ_NOSTATE, SXQ_CRC, SXQ_LFLUSH, SXQ_BIT_POPULATION_COUNT: begin
        if (req.cls == SXQ_LFLUSH) begin
          feat_ok = req.feat[7];
        end else if (req.cls == SXQ_BIT_POPULATION_COUNT) begin
          feat_ok = req.feat[6];
        end else if (req.cls == SXQ_CRC) begin
          feat_ok = req.feat[5];
        end else begin
          feat_ok = req.feat[0];
        end
        em_exempt = 1'b1;
        os_exempt = 1'b1;
        ts_exempt = 1'b1;
      end
      default: feat_ok = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // Alignment
  // ----------------------------------------------------------------
  always_comb begin
    mis128    = (req.size == SXQ_SZ128) && (req.addr_lo != 4'h0) && (req.cls != SXQ_MOVU);
    mis_small = 1'b0;
    case (req.size)
      SXQ_SZ16: mis_small = req.addr_lo[0];
      SXQ_SZ32: mis_small = |req.addr_lo[1:0];
      SXQ_SZ64: mis_small = |req.addr_lo[2:0];
      default:  mis_small = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // Fault priority
  // ----------------------------------------------------------------
  always_comb begin
    if (!feat_ok) begin
      req.fault = SXQ_UD;
    end else if (req.soft_trap && !em_exempt) begin
      req.fault = SXQ_UD;
    end else if (!req.state_save && !os_exempt) begin
      req.fault = SXQ_UD;
    end else if (req.task_sw && !ts_exempt) begin
      req.fault = SXQ_NM;
    end else if (req.page_miss) begin
      req.fault = SXQ_PF;
    end else if (req.seg_viol) begin
      req.fault = req.stack_ref ? SXQ_SS : SXQ_GP;
    end else if (mis128) begin
      req.fault = SXQ_GP;
    end else if (req.align_en && mis_small) begin
      req.fault = SXQ_AC;
    end else if (req.fp_unmasked && req.cls != SXQ_FPTRUNC) begin
      req.fault = req.vec_handler ? SXQ_XM : SXQ_UD;
    end else begin
      req.fault = SXQ_NONE;
    end
  end
endmodule // sxq_decide
`default_nettype wire

//--- sxq_qualifier.sv
// Top of the SIMD fault qualifier: control registers, bus slave, verdict
// Behaviour
// - Unsupported SIMD instruction raises invalid opcode
// - Identify leaf1 D: gen1 25, gen2 26, save 24
// - Identify leaf1 C: gen3 0, 9, 19, 20
// - Population count reported in leaf1 C bit 23
// - Setting state-save bit without feature: general protection
// - OS support taken only from two bits
// - State-save bit clear: invalid opcode, listed exemptions
// - Soft trap set: invalid opcode, listed exemptions
// - Missing generation flag: invalid opcode; flush, popcount own
// - Unmasked fp condition without handler: invalid opcode
// - Handler declared: execute, raise vector fp fault
// - Task switched set: device unavailable fault, listed exemptions
// - Support-bit faults skip fp store truncate
// - Vector control/status fields reset to zero
// - Memory faults raised as for ordinary instructions
// - Unaligned 128-bit reference: general protection, moves exempt
// - Unaligned 128-bit stack reference: general protection
// - Small alignment check needs both flags, level 3
// - Unaligned moves detect 16/32/64-bit misalignment
`timescale 1ns/1ps
`default_nettype none
`include "sxq_defs.svh"
module sxq_qualifier #(
  parameter bit HAS_GEN1   = 1'b1,
  parameter bit HAS_GEN2   = 1'b1,
  parameter bit HAS_GEN3   = 1'b1,
  parameter bit HAS_SUPP3  = 1'b1,
  parameter bit HAS_GEN41  = 1'b1,
  parameter bit HAS_GEN42  = 1'b1,
  parameter bit HAS_BIT_POPULATION_COUNT = 1'b1,
  parameter bit HAS_LFLUSH = 1'b1,
  parameter bit HAS_STATE_SAVE_FEATURE   = 1'b1
) (
  input  wire logic               mclk_in,
  input  wire logic               sys_rst_in,
  input  wire logic [4:0]         address_in,
  input  wire logic               read_in,
  input  wire logic               write_in,
  input  wire logic [31:0]        writedata_in,
  input  wire logic [3:0]         byteenable_in,
  output logic                    waitrequest_out,
  output logic [31:0]             readdata_out,
  input  wire logic               instr_valid_in,
  input  wire sxq_pkg::sxq_class_t instr_class_in,
  input  wire sxq_pkg::sxq_size_t  op_size_in,
  input  wire logic [3:0]         addr_lo_in,
  input  wire logic               stack_ref_in,
  input  wire logic               seg_viol_in,
  input  wire logic               page_miss_in,
  input  wire logic [5:0]         fp_flags_in,
  input  wire logic [1:0]         current_privilege_level_in,
  output logic                    done_out,
  output sxq_pkg::sxq_fault_t     fault_out,
  output logic                    commit_out,
  output logic                    cfg_gp_out
);
  import sxq_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] control_reg_zero;
  logic [31:0] control_reg_four;
  logic [31:0] flags_register;
  logic [31:0] vector_control_status;
  logic [31:0] status;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        done_q;
  logic        commit_q;
  logic        cfg_gp_q;
  sxq_fault_t  fault_q;

  logic        wr_fire;
  logic [31:0] be_mask;
  logic [31:0] wdata_four;
  logic        four_refused;
  logic        st_clear;
  logic [31:0] id_edx;
  logic [31:0] id_ecx;
  logic [31:0] feat_reg;
  logic [31:0] next_rdata;

  sxq_req_if req_if ();

  // ----------------------------------------------------------------
  // Identification words
  // ----------------------------------------------------------------
  always_comb begin
    id_edx = 32'h0000_0000;
    id_ecx = 32'h0000_0000;
    feat_reg = 32'h0000_0000;
    id_edx[`SXQ_B_ID_GEN1]   = HAS_GEN1;
    id_edx[`SXQ_B_ID_GEN2]   = HAS_GEN2;
    id_edx[`SXQ_B_ID_STATE_SAVE_FEATURE]   = HAS_STATE_SAVE_FEATURE;
    id_ecx[`SXQ_B_ID_GEN3]   = HAS_GEN3;
    id_ecx[`SXQ_B_ID_SUPP3]  = HAS_SUPP3;
    id_ecx[`SXQ_B_ID_GEN41]  = HAS_GEN41;
    id_ecx[`SXQ_B_ID_GEN42]  = HAS_GEN42;
    id_ecx[`SXQ_B_ID_BIT_POPULATION_COUNT] = HAS_BIT_POPULATION_COUNT;
    feat_reg[0] = HAS_LFLUSH;
  end

  // ----------------------------------------------------------------
  // Bus write qualification
  // ----------------------------------------------------------------
  assign wr_fire = write_in && !wait_q;
  assign be_mask = {{8{byteenable_in[3]}}, {8{byteenable_in[2]}},
                    {8{byteenable_in[1]}}, {8{byteenable_in[0]}}};
  assign wdata_four = ((control_reg_four & ~be_mask) | (writedata_in & be_mask))
                      & `SXQ_WM_CTL_FOUR;
  assign four_refused = wr_fire && (address_in == `SXQ_OFS_CTL_FOUR)
                        && wdata_four[`SXQ_B_STATE_SAVE] && !HAS_STATE_SAVE_FEATURE;
  assign st_clear = wr_fire && (address_in == `SXQ_OFS_STATUS)
                    && byteenable_in[1] && writedata_in[`SXQ_B_ST_CFG_GP];

  // ----------------------------------------------------------------
  // Avalon handshake
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wait_q <= 1'b1;
    end else if ((read_in || write_in) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  always_comb begin
    if (address_in == `SXQ_OFS_CTL_ZERO) begin
      next_rdata = control_reg_zero;
    end else if (address_in == `SXQ_OFS_CTL_FOUR) begin
      next_rdata = control_reg_four;
    end else if (address_in == `SXQ_OFS_FLAGS) begin
      next_rdata = flags_register;
    end else if (address_in == `SXQ_OFS_VCS) begin
      next_rdata = vector_control_status;
    end else if (address_in == `SXQ_OFS_ID_EDX) begin
      next_rdata = id_edx;
    end else if (address_in == `SXQ_OFS_ID_ECX) begin
      next_rdata = id_ecx;
    end else if (address_in == `SXQ_OFS_STATUS) begin
      next_rdata = status;
    end else if (address_in == `SXQ_OFS_FEAT) begin
      next_rdata = feat_reg;
    end else begin
      next_rdata = 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (read_in && wait_q) begin
      rdata_q <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      control_reg_zero <= `SXQ_RST_CTL_ZERO;
    end else if (wr_fire && address_in == `SXQ_OFS_CTL_ZERO) begin
      control_reg_zero <= ((control_reg_zero & ~be_mask) | (writedata_in & be_mask))
                          & `SXQ_WM_CTL_ZERO;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      control_reg_four <= `SXQ_RST_CTL_FOUR;
    end else if (wr_fire && address_in == `SXQ_OFS_CTL_FOUR && !four_refused) begin
      control_reg_four <= wdata_four;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      flags_register <= `SXQ_RST_FLAGS;
    end else if (wr_fire && address_in == `SXQ_OFS_FLAGS) begin
      flags_register <= ((flags_register & ~be_mask) | (writedata_in & be_mask))
                        & `SXQ_WM_FLAGS;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      vector_control_status <= `SXQ_RST_VCS;
    end else if (wr_fire && address_in == `SXQ_OFS_VCS) begin
      vector_control_status <= ((vector_control_status & ~be_mask) | (writedata_in & be_mask))
                               & `SXQ_WM_VCS;
    end
  end

  // ----------------------------------------------------------------
  // Status: last verdict and sticky refusal flag
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      status <= 32'h0000_0000;
    end else begin
      if (done_q) begin
        status[2:0] <= fault_q;
        status[`SXQ_B_ST_COMMIT] <= commit_q;
      end
      if (four_refused) begin
        status[`SXQ_B_ST_CFG_GP] <= 1'b1;
      end else if (st_clear) begin
        status[`SXQ_B_ST_CFG_GP] <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      cfg_gp_q <= 1'b0;
    end else begin
      cfg_gp_q <= four_refused;
    end
  end

  // ----------------------------------------------------------------
  // Decision inputs
  // ----------------------------------------------------------------
  assign req_if.cls         = instr_class_in;
  assign req_if.size        = op_size_in;
  assign req_if.addr_lo     = addr_lo_in;
  assign req_if.stack_ref   = stack_ref_in;
  assign req_if.seg_viol    = seg_viol_in;
  assign req_if.page_miss   = page_miss_in;
  assign req_if.fp_unmasked = |(fp_flags_in &
                              ~vector_control_status[`SXQ_B_VCS_MASK_HI:`SXQ_B_VCS_MASK_LO]);
  assign req_if.soft_trap   = control_reg_zero[`SXQ_B_SOFT_TRAP];
  assign req_if.task_sw     = control_reg_zero[`SXQ_B_TASK_SW];
  assign req_if.align_en    = control_reg_zero[`SXQ_B_ALIGN_MASK]
                              && flags_register[`SXQ_B_ALIGN_FLAG]
                              && (current_privilege_level_in == `SXQ_USER_CPL);
  assign req_if.state_save  = control_reg_four[`SXQ_B_STATE_SAVE];
  assign req_if.vec_handler = control_reg_four[`SXQ_B_VEC_HANDLER];
  assign req_if.feat        = {HAS_STATE_SAVE_FEATURE, HAS_LFLUSH, HAS_BIT_POPULATION_COUNT, HAS_GEN42, HAS_GEN41,
                               HAS_SUPP3, HAS_GEN3, HAS_GEN2, HAS_GEN1};

  sxq_decide u_decide (
    .req (req_if.qual)
  );

  // ----------------------------------------------------------------
  // Verdict registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      done_q   <= 1'b0;
      fault_q  <= SXQ_NONE;
      commit_q <= 1'b0;
    end else begin
      done_q   <= instr_valid_in;
      fault_q  <= instr_valid_in ? req_if.fault : SXQ_NONE;
      commit_q <= instr_valid_in && (req_if.fault == SXQ_NONE);
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign waitrequest_out = wait_q;
  assign readdata_out    = rdata_q;
  assign done_out        = done_q;
  assign fault_out       = fault_q;
  assign commit_out      = commit_q;
  assign cfg_gp_out      = cfg_gp_q;
endmodule // sxq_qualifier
`default_nettype wire

//--- sxq_qualifier_monitor.sv
// Port assertions of the SIMD fault qualifier, bound to its top
`timescale 1ns/1ps
`default_nettype none
`include "sxq_defs.svh"
module sxq_qualifier_monitor #(
  parameter bit HAS_STATE_SAVE_FEATURE = 1'b1
) (
  input wire logic                mclk_in,
  input wire logic                sys_rst_in,
  input wire logic [4:0]          address_in,
  input wire logic                write_in,
  input wire logic [31:0]         writedata_in,
  input wire logic [3:0]          byteenable_in,
  input wire logic                waitrequest_out,
  input wire logic                instr_valid_in,
  input wire sxq_pkg::sxq_class_t instr_class_in,
  input wire sxq_pkg::sxq_size_t  op_size_in,
  input wire logic [3:0]          addr_lo_in,
  input wire logic                seg_viol_in,
  input wire logic                page_miss_in,
  input wire logic [5:0]          fp_flags_in,
  input wire logic [1:0]          current_privilege_level_in,
  input wire logic                done_out,
  input wire sxq_pkg::sxq_fault_t fault_out,
  input wire logic                commit_out,
  input wire logic                cfg_gp_out
);
  import sxq_pkg::*;
  logic       trap, tsw, amask, save, hdl, aflag, wdone, gen, ok, user;
  logic [5:0] fmask;
  // ----
  // Shadow of control bits
  // ----
  assign wdone = write_in && !waitrequest_out;
  assign gen   = instr_class_in inside {SXQ_GEN1, SXQ_GEN2, SXQ_GEN3, SXQ_SUPP3, SXQ_GEN41, SXQ_GEN42};
  assign ok    = instr_valid_in && !trap && save && !tsw && !page_miss_in && !seg_viol_in;
  assign user  = amask && aflag && current_privilege_level_in == `SXQ_USER_CPL;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      {trap, tsw, amask, save, hdl, aflag, fmask} <= '0;
    end else if (wdone) begin
      if (address_in == `SXQ_OFS_CTL_ZERO && byteenable_in[0]) {tsw, trap} <= writedata_in[3:2];
      if (address_in == `SXQ_OFS_CTL_ZERO && byteenable_in[2]) amask <= writedata_in[18];
      if (address_in == `SXQ_OFS_CTL_FOUR && byteenable_in[1] && (HAS_STATE_SAVE_FEATURE || !writedata_in[9]))
        {hdl, save} <= writedata_in[10:9];
      if (address_in == `SXQ_OFS_FLAGS && byteenable_in[2]) aflag <= writedata_in[18];
      if (address_in == `SXQ_OFS_VCS && byteenable_in[0]) fmask[0] <= writedata_in[7];
      if (address_in == `SXQ_OFS_VCS && byteenable_in[1]) fmask[5:1] <= writedata_in[12:8];
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  AST_ANSWER: assert property (instr_valid_in |=> done_out)
    else $error("no verdict one cycle after an instruction");
  AST_NO_COMMIT: assert property (done_out && fault_out != SXQ_NONE |-> !commit_out)
    else $error("faulting instruction committed");
  AST_SOFT_TRAP: assert property (instr_valid_in && gen && trap |=> fault_out == SXQ_UD)
    else $error("soft trap did not give invalid opcode");
  AST_SAVE_CLEAR: assert property (instr_valid_in && (gen || instr_class_in == SXQ_MOVU) && !save
    |=> fault_out == SXQ_UD) else $error("state save clear did not give invalid opcode");
  AST_EXEMPT: assert property (instr_valid_in && !page_miss_in && !seg_viol_in && addr_lo_in == 4'h0
    && instr_class_in inside {SXQ_NOSTATE, SXQ_CRC, SXQ_BIT_POPULATION_COUNT} && fp_flags_in == 6'h00
    |=> fault_out == SXQ_NONE && commit_out) else $error("exempt instruction did not execute");
  AST_TASK_SW: assert property (instr_valid_in && gen && !trap && save && tsw |=> fault_out == SXQ_NM)
    else $error("task switched did not give device unavailable");
  AST_PAGE: assert property (instr_valid_in && gen && !trap && save && !tsw && page_miss_in
    |=> fault_out == SXQ_PF) else $error("page miss not reported");
  AST_MISALIGN: assert property (ok && gen && op_size_in == SXQ_SZ128 && addr_lo_in != 4'h0
    |=> fault_out == SXQ_GP) else $error("wide misaligned access not general protection");
  AST_FP_XM: assert property (ok && gen && addr_lo_in == 4'h0 && hdl && (fp_flags_in & ~fmask) != 6'h00
    |=> fault_out == SXQ_XM) else $error("unmasked fp condition not vector fault");
  AST_FP_UD: assert property (ok && gen && addr_lo_in == 4'h0 && !hdl && (fp_flags_in & ~fmask) != 6'h00
    |=> fault_out == SXQ_UD) else $error("fp condition without handler not invalid opcode");
  AST_ALIGN_HIT: assert property (ok && instr_class_in == SXQ_MOVU && op_size_in != SXQ_SZ128
    && addr_lo_in[0] && fp_flags_in == 6'h00 && user |=> fault_out == SXQ_AC) else $error("small misalign missed");
  AST_CFG_GP: assert property (wdone && address_in == `SXQ_OFS_CTL_FOUR && byteenable_in[1]
    && writedata_in[9] && !HAS_STATE_SAVE_FEATURE |-> ##[1:2] cfg_gp_out) else $error("refused write gave no pulse");
  cover property (done_out && fault_out == SXQ_XM);
  cover property (done_out && fault_out == SXQ_AC);
  cover property (cfg_gp_out);
endmodule // sxq_qualifier_monitor
bind sxq_qualifier sxq_qualifier_monitor #(.HAS_STATE_SAVE_FEATURE(HAS_STATE_SAVE_FEATURE)) sxq_qualifier_monitor_i (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .address_in(address_in), .write_in(write_in),
  .writedata_in(writedata_in), .byteenable_in(byteenable_in), .waitrequest_out(waitrequest_out),
  .instr_valid_in(instr_valid_in), .instr_class_in(instr_class_in), .op_size_in(op_size_in),
  .addr_lo_in(addr_lo_in), .seg_viol_in(seg_viol_in), .page_miss_in(page_miss_in), .fp_flags_in(fp_flags_in),
  .current_privilege_level_in(current_privilege_level_in), .done_out(done_out), .fault_out(fault_out),
  .commit_out(commit_out), .cfg_gp_out(cfg_gp_out));
`default_nettype wire

//--- sxq_qualifier_tb_top.sv
// Self-checking bench of the SIMD fault qualifier
`timescale 1ns/1ps
`default_nettype none
`include "sxq_defs.svh"
module sxq_qualifier_tb_top;
  import sxq_pkg::*;
  logic        mclk_in, sys_rst_in, rd, wr, iv, stk, seg, pg, wq1, wq2, dn1, cm1, gp1, gp2;
  logic [4:0]  adr;
  logic [31:0] wd, q1, q2, r1, r2;
  logic [3:0]  be, alo;
  logic [5:0]  fp;
  logic [1:0]  lvl, gpseen;
  sxq_class_t  cls;
  sxq_size_t   sz;
  sxq_fault_t  fl1, fl2;
  int          failures, n_checks;
  sxq_class_t  ex4 [4] = '{SXQ_NOSTATE, SXQ_LFLUSH, SXQ_CRC, SXQ_BIT_POPULATION_COUNT};
  sxq_qualifier sxq_qualifier_i (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .address_in(adr), .read_in(rd), .write_in(wr),
    .writedata_in(wd), .byteenable_in(be), .waitrequest_out(wq1), .readdata_out(q1),
    .instr_valid_in(iv), .instr_class_in(cls), .op_size_in(sz), .addr_lo_in(alo), .stack_ref_in(stk),
    .seg_viol_in(seg), .page_miss_in(pg), .fp_flags_in(fp), .current_privilege_level_in(lvl),
    .done_out(dn1), .fault_out(fl1), .commit_out(cm1), .cfg_gp_out(gp1));
  sxq_qualifier #(.HAS_STATE_SAVE_FEATURE(1'b0), .HAS_GEN3(1'b0)) sxq_qualifier_nofx_i (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .address_in(adr), .read_in(rd), .write_in(wr),
    .writedata_in(wd), .byteenable_in(be), .waitrequest_out(wq2), .readdata_out(q2),
    .instr_valid_in(iv), .instr_class_in(cls), .op_size_in(sz), .addr_lo_in(alo), .stack_ref_in(stk),
    .seg_viol_in(seg), .page_miss_in(pg), .fp_flags_in(fp), .current_privilege_level_in(lvl),
    .done_out(), .fault_out(fl2), .commit_out(), .cfg_gp_out(gp2));
  // ----
  // Tasks
  // ----
  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_fault(input sxq_fault_t g, input sxq_fault_t e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] t=%0t fault got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    @(posedge mclk_in);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge mclk_in);
      n++;
    end while (wq1 !== 1'b0 && n < 20);
    r1 = q1;
    r2 = q2;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 20) begin
      failures++;
      report_and_stop();
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [31:0] e1, input logic [31:0] e2);
    bus(1'b0, a, 32'h0, 4'hF);
    chk_word(r1, e1);
    chk_word(r2, e2);
  endtask
  task automatic exec(input sxq_class_t c, input sxq_size_t s, input logic [3:0] a, input logic [2:0] f,
                      input sxq_fault_t e1, input sxq_fault_t e2);
    @(posedge mclk_in);
    cls <= c;
    sz <= s;
    alo <= a;
    {stk, seg, pg} <= f;
    iv <= 1'b1;
    @(posedge mclk_in);
    iv <= 1'b0;
    @(negedge mclk_in);
    chk_word({30'h0, dn1, cm1}, {30'h0, 1'b1, e1 == SXQ_NONE});
    chk_fault(fl1, e1);
    chk_fault(fl2, e2);
  endtask
  // ----
  // Sequence
  // ----
  always #20 mclk_in = ~mclk_in;
  initial begin
    mclk_in = 1'b0;
    sys_rst_in = 1'b1;
    {rd, wr, iv, stk, seg, pg, adr, wd, be, alo, fp, lvl} = '0;
    cls = SXQ_GEN1;
    sz = SXQ_SZ32;
    failures = 0;
    n_checks = 0;
    repeat (20) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rdchk(5'h02, 32'h0, 32'h0);
    rdchk(`SXQ_OFS_VCS, 32'h0, 32'h0);
    rdchk(`SXQ_OFS_ID_EDX, 32'h0700_0000, 32'h0600_0000);
    rdchk(`SXQ_OFS_ID_ECX, 32'h0098_0201, 32'h0098_0200);
    bus(1'b1, `SXQ_OFS_CTL_ZERO, 32'hFFFF_FFFF, 4'h1);
    rdchk(`SXQ_OFS_CTL_ZERO, 32'h0000_000E, 32'h0000_000E);
    bus(1'b1, `SXQ_OFS_CTL_ZERO, 32'h0000_0002, 4'hF);
    for (int k = 0; k < 12; k++) begin
      exec(sxq_class_t'(k), SXQ_SZ32, 4'h0, 3'b000, sxq_fault_t'(k < 6),
           sxq_fault_t'(k < 6 || k == 11));
    end
    bus(1'b1, `SXQ_OFS_CTL_FOUR, 32'h0000_0600, 4'hF);
    gpseen = 2'b00;
    repeat (3) begin
      @(negedge mclk_in);
      gpseen |= {gp2, gp1};
    end
    chk_word({30'h0, gpseen}, 32'h2);
    rdchk(`SXQ_OFS_CTL_FOUR, 32'h0000_0600, 32'h0);
    rdchk(`SXQ_OFS_STATUS, 32'h0001_0000, 32'h0000_0101);
    bus(1'b1, `SXQ_OFS_STATUS, 32'h0000_0100, 4'hF);
    rdchk(`SXQ_OFS_STATUS, 32'h0001_0000, 32'h0000_0001);
    for (int k = 0; k < 6; k++) exec(sxq_class_t'(k), SXQ_SZ32, 4'h0, 3'b000, SXQ_NONE, SXQ_UD);
    exec(SXQ_MOVU, SXQ_SZ128, 4'h8, 3'b000, SXQ_NONE, SXQ_UD);
    exec(SXQ_GEN2, SXQ_SZ128, 4'h8, 3'b000, SXQ_GP, SXQ_UD);
    exec(SXQ_GEN2, SXQ_SZ128, 4'h8, 3'b100, SXQ_GP, SXQ_UD);
    exec(SXQ_GEN1, SXQ_SZ32, 4'h0, 3'b001, SXQ_PF, SXQ_UD);
    exec(SXQ_GEN1, SXQ_SZ32, 4'h0, 3'b110, SXQ_SS, SXQ_UD);
    exec(SXQ_GEN1, SXQ_SZ32, 4'h0, 3'b010, SXQ_GP, SXQ_UD);
    @(posedge mclk_in) fp <= 6'h01;
    exec(SXQ_GEN1, SXQ_SZ32, 4'h0, 3'b000, SXQ_XM, SXQ_UD);
    bus(1'b1, `SXQ_OFS_VCS, 32'h0000_FFFF, 4'hF);
    exec(SXQ_GEN1, SXQ_SZ32, 4'h0, 3'b000, SXQ_NONE, SXQ_UD);
    bus(1'b1, `SXQ_OFS_VCS, 32'h0, 4'hF);
    bus(1'b1, `SXQ_OFS_CTL_FOUR, 32'h0000_0200, 4'hF);
    exec(SXQ_GEN1, SXQ_SZ32, 4'h0, 3'b000, SXQ_UD, SXQ_UD);
    @(posedge mclk_in) fp <= 6'h00;
    bus(1'b1, `SXQ_OFS_CTL_ZERO, 32'h0000_000E, 4'hF);
    for (int k = 0; k < 6; k++) exec(sxq_class_t'(k), SXQ_SZ32, 4'h0, 3'b000, SXQ_UD, SXQ_UD);
    exec(SXQ_MMX64, SXQ_SZ32, 4'h0, 3'b000, SXQ_UD, SXQ_UD);
    for (int k = 0; k < 4; k++) exec(ex4[k], SXQ_SZ32, 4'h0, 3'b000, SXQ_NONE, SXQ_NONE);
    bus(1'b1, `SXQ_OFS_CTL_ZERO, 32'h0000_000A, 4'hF);
    exec(SXQ_GEN3, SXQ_SZ32, 4'h0, 3'b000, SXQ_NM, SXQ_UD);
    for (int k = 0; k < 4; k++) exec(ex4[k], SXQ_SZ32, 4'h0, 3'b000, SXQ_NONE, SXQ_NONE);
    bus(1'b1, `SXQ_OFS_CTL_ZERO, 32'h0004_0002, 4'hF);
    bus(1'b1, `SXQ_OFS_FLAGS, 32'h0004_0000, 4'hF);
    @(posedge mclk_in) lvl <= 2'h3;
    for (int k = 0; k < 3; k++) exec(SXQ_MOVU, sxq_size_t'(k), 4'h1, 3'b000, SXQ_AC, SXQ_UD);
    rdchk(`SXQ_OFS_STATUS, 32'h0000_0006, 32'h0000_0101);
    @(posedge mclk_in) lvl <= 2'h0;
    exec(SXQ_MOVU, SXQ_SZ32, 4'h1, 3'b000, SXQ_NONE, SXQ_UD);
    report_and_stop();
  end
endmodule // sxq_qualifier_tb_top
`default_nettype wire
